// [rtl/pcx_defs.svh]
`ifndef PCX_DEFS_SVH
`define PCX_DEFS_SVH

// Geometry
`define PCX_NPORT        4
`define PCX_NPIN         32
`define PCX_NSIG         11
`define PCX_NPER         5
`define PCX_SIGW         4
`define PCX_PINW         5

// Register byte offsets
`define PCX_OFF_DATA     8'h00
`define PCX_OFF_LATCH    8'h10
`define PCX_OFF_BIT      8'h20
`define PCX_OFF_MODE     8'h24
`define PCX_OFF_CFG0     8'h28
`define PCX_OFF_CFG1     8'h2c
`define PCX_OFF_CFG2     8'h30
`define PCX_OFF_OWNED    8'h34
`define PCX_MASK_PORT    8'hf0
`define PCX_MASK_WORD    8'hfc

// Field positions
`define PCX_CFG0_TW      0
`define PCX_CFG0_SPI     1
`define PCX_CFG0_S0      2
`define PCX_CFG1_CNV2    0
`define PCX_CFG1_S1      2
`define PCX_CFG2_XBAR    4
`define PCX_CFG2_PUDIS   7
`define PCX_BIT_VAL      8

// Reset values
`define PCX_RST_LATCH    32'hffffffff
`define PCX_RST_MODE     32'h00000000
`define PCX_RST_CFG      8'h00

// Per-signal attributes, bit i = signal i in priority order
`define PCX_SIG_INONLY   11'h602
`define PCX_SIG_FORCE_OD 11'h00c
`define PCX_SIG_RX0      1
`define PCX_SIG_RX1      9

`endif

// [rtl/pcx_pkg.sv]
package pcx_pkg;
    // Peripherals in crossbar priority order, highest first
    typedef enum logic [2:0] {
        PCX_PER_S0   = 3'h0,
        PCX_PER_TW   = 3'h1,
        PCX_PER_SPI  = 3'h2,
        PCX_PER_S1   = 3'h3,
        PCX_PER_CNV2 = 3'h4
    } pcx_per_t;

    // Owner of each peripheral signal, signal 0 first
    localparam pcx_per_t PCX_SIG_OWNER [11] = '{
        PCX_PER_S0, PCX_PER_S0,
        PCX_PER_TW, PCX_PER_TW,
        PCX_PER_SPI, PCX_PER_SPI, PCX_PER_SPI, PCX_PER_SPI,
        PCX_PER_S1, PCX_PER_S1,
        PCX_PER_CNV2
    };

    typedef logic [3:0] pcx_sig_idx_t;
    typedef logic [4:0] pcx_pin_idx_t;
endpackage : pcx_pkg

// [rtl/pcx_xbar_if.sv]
`timescale 1ns/10ps
`include "pcx_defs.svh"

interface pcx_xbar_if;
    import pcx_pkg::*;
    logic         [`PCX_NSIG-1:0] sig_en;
    logic         [`PCX_NPIN-1:0] pin_owned;
    pcx_sig_idx_t                 pin_sig [`PCX_NPIN];
    pcx_pin_idx_t                 sig_pin [`PCX_NSIG];

    modport alloc (input sig_en, output pin_owned, output pin_sig, output sig_pin);
    modport user  (output sig_en, input pin_owned, input pin_sig, input sig_pin);
endinterface : pcx_xbar_if

// [rtl/pcx_alloc.sv]
`timescale 1ns/10ps
`include "pcx_defs.svh"

module pcx_alloc
    import pcx_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  clk_en,
    pcx_xbar_if.alloc  xb
);
    // Running count of enabled signals ahead of each signal
    logic [`PCX_PINW:0] pos [`PCX_NSIG+1];
    assign pos[0] = '0;

    genvar i;
    genvar p;
    generate
        for (i = 0; i < `PCX_NSIG; i++)
        begin : g_sig
            assign pos[i+1] = pos[i] + {{`PCX_PINW{1'b0}}, xb.sig_en[i]};
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    xb.sig_pin[i] <= '0;
                else if (clk_en)
                    xb.sig_pin[i] <= pos[i][`PCX_PINW-1:0];
            end
        end

        for (p = 0; p < `PCX_NPIN; p++)
        begin : g_pin
            logic         hit;
            pcx_sig_idx_t who;
            always_comb
            begin
                hit = 1'b0;
                who = '0;
                for (int k = 0; k < `PCX_NSIG; k++)
                begin
                    if (xb.sig_en[k] && pos[k] == (`PCX_PINW+1)'(p))
                    begin
                        hit = 1'b1;
                        who = pcx_sig_idx_t'(k);
                    end
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    xb.pin_owned[p] <= 1'b0;
                    xb.pin_sig[p]   <= '0;
                end
                else if (clk_en)
                begin
                    xb.pin_owned[p] <= hit;
                    xb.pin_sig[p]   <= who;
                end
            end
        end
    endgenerate
endmodule : pcx_alloc

// [rtl/pcx_port_io.sv]
`timescale 1ns/10ps
`include "pcx_defs.svh"

module pcx_port_io
    import pcx_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [`PCX_NPIN-1:0] pin_in,
    output logic      [`PCX_NPIN-1:0] pin_out,
    output logic      [`PCX_NPIN-1:0] pin_oe,
    output logic      [`PCX_NPIN-1:0] pin_pullup_en,
    input  wire logic [`PCX_NSIG-1:0] sig_out,
    input  wire logic [`PCX_NSIG-1:0] sig_drive,
    output logic      [`PCX_NSIG-1:0] sig_in,
    input  wire logic                 serial0_mode0,
    input  wire logic                 serial1_mode0
);
    logic [`PCX_NPIN-1:0] latch_r;
    logic [`PCX_NPIN-1:0] latch_nxt;
    logic [`PCX_NPIN-1:0] mode_r;
    logic [7:0]           cfg0_r;
    logic [7:0]           cfg1_r;
    logic [7:0]           cfg2_r;
    logic [4:0]           bit_sel_r;
    logic [`PCX_NPIN-1:0] sync1_r;
    logic [`PCX_NPIN-1:0] sync2_r;
    logic [`PCX_NPIN-1:0] sync3_r;
    logic [`PCX_NPIN-1:0] level_r;

    pcx_xbar_if xb ();

    pcx_alloc u_alloc (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .xb      (xb.alloc)
    );

    // Peripheral enables mapped onto their signals, all signals at once
    logic [`PCX_NPER-1:0] per_en;
    assign per_en[PCX_PER_S0]   = cfg0_r[`PCX_CFG0_S0];
    assign per_en[PCX_PER_TW]   = cfg0_r[`PCX_CFG0_TW];
    assign per_en[PCX_PER_SPI]  = cfg0_r[`PCX_CFG0_SPI];
    assign per_en[PCX_PER_S1]   = cfg1_r[`PCX_CFG1_S1];
    assign per_en[PCX_PER_CNV2] = cfg1_r[`PCX_CFG1_CNV2];

    genvar s;
    generate
        for (s = 0; s < `PCX_NSIG; s++)
        begin : g_sen
            assign xb.sig_en[s] = per_en[PCX_SIG_OWNER[s]];
        end
    endgenerate

    wire xbar_en = cfg2_r[`PCX_CFG2_XBAR];
    wire pu_dis  = cfg2_r[`PCX_CFG2_PUDIS];

    // Receive lines become bidirectional open-drain in serial mode 0
    logic [`PCX_NSIG-1:0] mode0_rx;
    assign mode0_rx = ({{(`PCX_NSIG-1){1'b0}}, serial0_mode0} << `PCX_SIG_RX0)
                    | ({{(`PCX_NSIG-1){1'b0}}, serial1_mode0} << `PCX_SIG_RX1);
    wire [`PCX_NSIG-1:0] sig_inonly = `PCX_SIG_INONLY & ~mode0_rx;
    wire [`PCX_NSIG-1:0] sig_od     = `PCX_SIG_FORCE_OD | mode0_rx;

    // APB decode
    wire         acc      = psel & penable;
    wire         wr_en    = acc & pready & pwrite & clk_en;
    wire [7:0]   wbyte    = pwdata[7:0];
    wire [1:0]   pidx     = paddr[3:2];
    wire [7:0]   a_port   = paddr & `PCX_MASK_PORT;
    wire [7:0]   a_word   = paddr & `PCX_MASK_WORD;
    wire         a_data   = a_port == `PCX_OFF_DATA;
    wire         a_latch  = a_port == `PCX_OFF_LATCH;
    wire         a_bit    = a_word == `PCX_OFF_BIT;
    wire         a_mode   = a_word == `PCX_OFF_MODE;
    wire         a_cfg0   = a_word == `PCX_OFF_CFG0;
    wire         a_cfg1   = a_word == `PCX_OFF_CFG1;
    wire         a_cfg2   = a_word == `PCX_OFF_CFG2;
    wire         a_owned  = a_word == `PCX_OFF_OWNED;
    wire         a_ok     = (a_data | a_latch | a_bit | a_mode | a_cfg0 | a_cfg1
                            | a_cfg2 | a_owned) & (paddr[1:0] == 2'h0);
    wire [4:0]   wbit     = pwdata[4:0];

    // Byte write through either the pin view or latch view; single-bit write via bit port
    logic [`PCX_NPIN-1:0] byte_mask;
    logic [`PCX_NPIN-1:0] bit_mask;
    assign byte_mask = (wr_en & (a_data | a_latch))
                     ? ({{(`PCX_NPIN-8){1'b0}}, 8'hff} << {pidx, 3'h0}) : '0;
    assign bit_mask  = (wr_en & a_bit)
                     ? ({{(`PCX_NPIN-1){1'b0}}, 1'b1} << wbit) : '0;
    assign latch_nxt = (latch_r & ~byte_mask & ~bit_mask)
                     | ({`PCX_NPORT{wbyte}} & byte_mask)
                     | ({`PCX_NPIN{pwdata[`PCX_BIT_VAL]}} & bit_mask);

    // Read selection: data offsets show pins, latch offsets serve read-modify-write
    wire [7:0] pin_byte   = level_r[{pidx, 3'h0} +: 8];
    wire [7:0] latch_byte = latch_r[{pidx, 3'h0} +: 8];
    wire [31:0] rd_mux =
        a_data  ? {24'h0, pin_byte} :
        a_latch ? {24'h0, latch_byte} :
        a_bit   ? ({31'h0, latch_r[bit_sel_r]} << `PCX_BIT_VAL)
                  | {31'h0, level_r[bit_sel_r]} :
        a_mode  ? mode_r :
        a_cfg0  ? {24'h0, cfg0_r} :
        a_cfg1  ? {24'h0, cfg1_r} :
        a_cfg2  ? {24'h0, cfg2_r} :
        a_owned ? (xb.pin_owned & {`PCX_NPIN{xbar_en}}) :
                  32'h0;

    // APB slave: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~a_ok;
            prdata  <= (acc & ~pready & ~pwrite & a_ok) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_r   <= `PCX_RST_LATCH;
            mode_r    <= `PCX_RST_MODE;
            cfg0_r    <= `PCX_RST_CFG;
            cfg1_r    <= `PCX_RST_CFG;
            cfg2_r    <= `PCX_RST_CFG;
            bit_sel_r <= 5'h0;
        end
        else if (clk_en)
        begin
            latch_r <= latch_nxt;
            if (wr_en & a_mode)
                mode_r <= pwdata;
            if (wr_en & a_cfg0)
                cfg0_r <= wbyte;
            if (wr_en & a_cfg1)
                cfg1_r <= wbyte;
            if (wr_en & a_cfg2)
                cfg2_r <= wbyte;
            if (wr_en & a_bit)
                bit_sel_r <= wbit;
        end
    end

    // Pin input synchroniser; level changes once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
            level_r <= '1;
        end
        else if (clk_en)
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (level_r & (sync2_r ^ sync3_r));
        end
    end

    // Per-pin output driver
    genvar p;
    generate
        for (p = 0; p < `PCX_NPIN; p++)
        begin : g_pin
            pcx_sig_idx_t sidx;
            assign sidx = xb.pin_sig[p];
            wire owned = xb.pin_owned[p];
            wire pv    = owned ? sig_out[sidx] : latch_r[p];
            wire pdrv  = owned ? (sig_drive[sidx] & ~sig_inonly[sidx])
                               : 1'b1;
            wire pod   = ~mode_r[p] | (owned & sig_od[sidx]);
            // Open-drain only drives a 0; push-pull drives both levels
            wire oe    = xbar_en & pdrv & (~pv | ~pod);
            wire pu    = ~pu_dis & ~(oe & ~pv);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_out[p]       <= 1'b1;
                    pin_oe[p]        <= 1'b0;
                    pin_pullup_en[p] <= 1'b1;
                end
                else if (clk_en)
                begin
                    pin_out[p]       <= pv;
                    pin_oe[p]        <= oe;
                    pin_pullup_en[p] <= pu;
                end
            end
        end

        // Peripheral inputs follow the pin their signal was given; idle high otherwise
        for (s = 0; s < `PCX_NSIG; s++)
        begin : g_sin
            wire live = xbar_en & xb.sig_en[s];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sig_in[s] <= 1'b1;
                else if (clk_en)
                    sig_in[s] <= live ? level_r[xb.sig_pin[s]] : 1'b1;
            end
        end
    endgenerate
endmodule : pcx_port_io

// [test/pcx_pin_model.sv]
`timescale 1ns/10ps

module pcx_pin_model (
    input  wire logic        pclk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pullup_en,
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pin_lvl
);
    // A floating pin with no pull-up shows a pattern that moves every cycle
    logic [31:0] flt_r = 32'h5555aaaa;

    always_ff @(posedge pclk)
        flt_r <= ~flt_r;

    // Outside circuitry only drives pins the device leaves undriven
    assign pin_lvl = (pin_oe & pin_out)
                   | (~pin_oe & ext_en & ext_val)
                   | (~pin_oe & ~ext_en & (pin_pullup_en | flt_r));
endmodule : pcx_pin_model

// [test/pcx_port_io_sva.sv]
`timescale 1ns/10ps
`include "pcx_defs.svh"

module pcx_port_io_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pullup_en
);
    logic        xen_r;
    logic        pud_r;
    logic [31:0] mode_r;
    logic        wr_acc;

    assign wr_acc = psel && penable && pready && pwrite && clk_en;

    // Shadow of the enable, pull-up and mode settings seen on the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xen_r  <= 1'b0;
            pud_r  <= 1'b0;
            mode_r <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == `PCX_OFF_CFG2)
                {pud_r, xen_r} <= {pwdata[7], pwdata[4]};
            if (paddr == `PCX_OFF_MODE)
                mode_r <= pwdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ans; psel && penable && !pready && clk_en |=> pready; endproperty
    property p_one; pready && clk_en |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_rd0; !pready |-> prdata == '0; endproperty
    property p_xoff; !xen_r && !$past(xen_r) && !$past(xen_r, 2) |-> pin_oe == '0; endproperty
    property p_pud; pud_r && $past(pud_r) |-> pin_pullup_en == '0; endproperty
    property p_pulow; (pin_oe & ~pin_out & pin_pullup_en) == '0; endproperty
    property p_od; (pin_oe & pin_out & ~mode_r & ~$past(mode_r)) == '0; endproperty

    a_ans: assert property (p_ans) else $error("pready late");
    a_one: assert property (p_one) else $error("pready held");
    a_err: assert property (p_err) else $error("pslverr without pready");
    a_rd0: assert property (p_rd0) else $error("prdata not zero");
    a_xoff: assert property (p_xoff) else $error("driver on while crossbar off");
    a_pud: assert property (p_pud) else $error("pull-up on while disabled");
    a_pulow: assert property (p_pulow) else $error("pull-up on driven low pin");
    a_od: assert property (p_od) else $error("open-drain pin driven high");

    c_en: cover property (wr_acc && paddr == `PCX_OFF_CFG2 && pwdata[4]);
    c_err: cover property (pslverr);
    c_pp: cover property (|(pin_oe & pin_out));
endmodule : pcx_port_io_sva

bind pcx_port_io pcx_port_io_sva u_sva (.pclk, .presetn, .clk_en, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe, .pin_pullup_en);

// [test/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_q;
    logic        serial0_mode0 = 1'b0, serial1_mode0 = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [10:0] sig_out = 11'h000, sig_drive = 11'h000, sig_in;
    logic [31:0] pwdata = 32'h0, prdata, pin_in, pin_out, pin_oe, pin_pullup_en;
    logic [31:0] ext_en = 32'h0, ext_val = 32'h0, rnd = 32'h000133fd;
    logic [31:0] lat = 32'hffffffff, mode = 32'h0, q;
    logic [1:0]  p;
    logic [7:0]  c0_tab [8] = '{8'h04, 8'h01, 8'h02, 8'h00, 8'h00, 8'h07, 8'h02, 8'h05};
    logic [7:0]  c1_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h05, 8'h01, 8'h04};
    logic [31:0] ow_tab [8] = '{32'h3, 32'h3, 32'hf, 32'h3, 32'h1, 32'h7ff, 32'h1f, 32'h3f};
    int          err_total = 0, checks_done = 0;

    always #20 pclk = ~pclk;

    pcx_port_io u_dut (.pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .sig_out,
        .sig_drive, .sig_in, .serial0_mode0, .serial1_mode0);
    pcx_pin_model u_pins (.pclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val,
        .pin_lvl(pin_in));

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task summarize;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        err_q = pslverr;
        if (n >= 20)
        begin
            err_total++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    initial
    begin
        tick(6);
        presetn <= 1'b1;
        tick(1);
        chk("oe_rst", 32'h0, pin_oe);
        chk("pu_rst", 32'hffffffff, pin_pullup_en);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(8'h10 + i * 4), 32'h0);
            chk("latch_rst", 32'hff, q);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk("mode_rst", 32'h0, q);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err_q});
        apb(1'b1, 8'h00, 32'h0);
        lat[7:0] = 8'h00;
        tick(2);
        chk("oe_off", 32'h0, pin_oe);
        $display("test reset done");
        apb(1'b1, 8'h30, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            mode = rnd;
            apb(1'b1, 8'h24, mode);
            rnd = lfsr(rnd);
            p = rnd[9:8];
            lat[p * 8 +: 8] = rnd[7:0];
            apb(1'b1, {4'h0, p, 2'b00}, {24'h0, rnd[7:0]});
            tick(2);
            chk("oe", mode | ~lat, pin_oe);
            chk("out", lat & mode, pin_out & pin_oe);
            chk("pullup", lat, pin_pullup_en);
            apb(1'b0, {4'h1, p, 2'b00}, 32'h0);
            chk("rmw", {24'h0, lat[p * 8 +: 8]}, q);
        end
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            lat[rnd[4:0]] = rnd[12];
            apb(1'b1, 8'h20, {23'h0, rnd[12], 3'h0, rnd[4:0]});
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("bit_rd", {23'h0, lat[rnd[4:0]], 8'h0}, q & 32'h100);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(8'h10 + i * 4), 32'h0);
            chk("bit_wr", {24'h0, lat[i * 8 +: 8]}, q);
        end
        $display("test gpio done");
        apb(1'b1, 8'h24, 32'h0);
        for (int i = 0; i < 4; i++)
            apb(1'b1, 8'(i * 4), 32'hff);
        rnd = lfsr(rnd);
        ext_en <= 32'hffffffff;
        ext_val <= rnd;
        tick(6);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("pin_rd", {24'h0, rnd[i * 8 +: 8]}, q);
        end
        apb(1'b1, 8'h30, 32'h90);
        tick(2);
        chk("pud", 32'h0, pin_pullup_en);
        apb(1'b1, 8'h30, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 8'h28, {24'h0, c0_tab[i]});
            apb(1'b1, 8'h2c, {24'h0, c1_tab[i]});
            tick(2);
            apb(1'b0, 8'h34, 32'h0);
            chk("owned", ow_tab[i], q);
        end
        $display("test alloc done");
        apb(1'b1, 8'h28, 32'h04);
        apb(1'b1, 8'h24, 32'h3);
        apb(1'b1, 8'h00, 32'h0);
        rnd = lfsr(rnd);
        sig_drive <= 11'h003;
        sig_out <= {10'h001, rnd[0]};
        tick(6);
        chk("s0_oe", 32'h1, pin_oe & 32'h3);
        chk("s0_tx", {31'h0, rnd[0]}, pin_out & 32'h1);
        chk("s0_rx", {31'h0, ext_val[1]}, {31'h0, sig_in[1]});
        apb(1'b0, 8'h00, 32'h0);
        chk("s0_pin", {30'h0, ext_val[1], rnd[0]}, q & 32'h3);
        sig_out <= {10'h000, rnd[0]};
        serial0_mode0 <= 1'b1;
        tick(3);
        chk("m0_drv", 32'h3, pin_oe & 32'h3);
        sig_out <= {10'h001, rnd[0]};
        tick(3);
        chk("m0_od", 32'h1, pin_oe & 32'h3);
        serial0_mode0 <= 1'b0;
        apb(1'b1, 8'h28, 32'h01);
        sig_drive <= 11'h00c;
        sig_out <= 11'h004;
        tick(3);
        chk("tw_od", 32'h2, pin_oe & 32'h3);
        clk_en <= 1'b0;
        sig_out <= 11'h008;
        tick(4);
        chk("frz_oe", 32'h2, pin_oe & 32'h3);
        clk_en <= 1'b1;
        tick(3);
        chk("tw_od2", 32'h1, pin_oe & 32'h3);
        $display("test serial done");
        summarize();
    end
endmodule : tb_top
